// File: include/vector_map_defines.svh
// Purpose: Constants for the reset and interrupt vector mapper
// Assumes: Word-addressed program memory, 14-bit program counter
// Notes: Addresses are program word addresses
`ifndef VECTOR_MAP_DEFINES_SVH
`define VECTOR_MAP_DEFINES_SVH

`define PC_WIDTH 14
`define SRC_COUNT 25
`define SRC_WIDTH 5
`define VEC_WIDTH 5
`define RESET_ADDR 14'h0000
`define VEC_SPACING 14'h0002
`define BOOT_VEC_OFFSET 14'h0002
`define BOOT_START_DEFAULT 14'h1c00
`define FUSE_PROGRAMMED 1'b0
`define FUSE_SETTLE 2'h3

`endif

// File: include/vector_map_pkg.sv
// Purpose: Types for the reset and interrupt vector mapper
// Assumes: Constants come from vector_map_defines.svh
// Notes: Source numbering is vector number minus two
`include "vector_map_defines.svh"
package vector_map_pkg;
    typedef logic [`PC_WIDTH-1:0] pc_t;
    typedef enum logic [`SRC_WIDTH-1:0] {
        src_ext_request_zero, src_ext_request_one,
        src_pin_change_request_zero, src_pin_change_request_one, src_pin_change_request_two,
        src_watchdog_timeout_source,
        src_timer2_compare_a, src_timer2_compare_b, src_timer2_overflow,
        src_timer1_capture, src_timer1_compare_a, src_timer1_compare_b, src_timer1_overflow,
        src_timer0_compare_a, src_timer0_compare_b, src_timer0_overflow,
        src_transfer_complete,
        src_rx_complete, src_tx_buffer_empty, src_tx_complete,
        src_conversion_complete, src_nv_data_ready, src_analog_compare,
        src_two_wire_serial_unit, src_program_store_ready
    } source_t;
    typedef enum {st_reset_pending, st_running} state_t;
endpackage

// File: design/reset_interrupt_vector_mapper.sv
// Purpose: Fetch address for reset and for each accepted interrupt source
// Assumes: Core gives one-cycle accept pulse with the source number
// Notes: Boot section start comes from a size decoder outside this block
//
// What this block does
// - Reset fetches from word zero normally
// - External requests vector to two and four
// - Pin-change requests vector to six, eight, ten
// - Watchdog time-out vectors to twelve
// - Timer two sources vector to 0x0e-0x12
// - Timer one sources vector to 0x14-0x1a
// - Timer zero sources vector to 0x1c-0x20
// - Serial transfer complete vectors to 0x22
// - Serial port sources vector to 0x24-0x28
// - Converter, data memory, comparator at 0x2a-0x2e
// - Two-wire at 0x30, store ready last
// - Programmed fuse moves reset to boot start
// - Select bit adds boot start to vectors
// - Fuse moves reset, select bit moves vectors
// - Fuse low means programmed
// - Vector fetched only when interrupt is taken
`timescale 1ns/10ps
`include "vector_map_defines.svh"
module reset_interrupt_vector_mapper
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Configuration
    input wire logic boot_reset_fuse,
    input wire logic vector_base_select,
    input wire logic [`PC_WIDTH-1:0] boot_start,
    // Accepted interrupt from the core
    input wire logic irq_accept,
    input wire logic [`SRC_WIDTH-1:0] irq_source,
    // Fetch request to the core
    output logic fetch_valid,
    output logic fetch_is_reset,
    output logic [`PC_WIDTH-1:0] fetch_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // Internal reset and fuse filter
    logic rst_meta;
    logic rst_sync_n;
    logic fuse_s1;
    logic fuse_s2;
    logic fuse_s3;
    logic [1:0] settle_count;
    logic fuse_settled;
    // Sequencing
    vector_map_pkg::state_t state;
    vector_map_pkg::state_t next_state;
    // Fetch decode
    logic source_ok;
    logic reset_fetch;
    logic irq_fetch;
    logic next_valid;
    logic next_is_reset;
    vector_map_pkg::pc_t vector_base;
    vector_map_pkg::pc_t next_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Table position of a source; vector one is reset and never comes from here
    function automatic logic [`VEC_WIDTH-1:0] vector_number(
        input logic [`SRC_WIDTH-1:0] src
    );
        case (src)
            // External requests
            vector_map_pkg::src_ext_request_zero: vector_number = 5'h02;
            vector_map_pkg::src_ext_request_one: vector_number = 5'h03;

            // Pin-change requests
            vector_map_pkg::src_pin_change_request_zero: vector_number = 5'h04;
            vector_map_pkg::src_pin_change_request_one: vector_number = 5'h05;
            vector_map_pkg::src_pin_change_request_two: vector_number = 5'h06;

            // Watchdog
            vector_map_pkg::src_watchdog_timeout_source: vector_number = 5'h07;

            // Timer two
            vector_map_pkg::src_timer2_compare_a: vector_number = 5'h08;
            vector_map_pkg::src_timer2_compare_b: vector_number = 5'h09;
            vector_map_pkg::src_timer2_overflow: vector_number = 5'h0a;

            // Timer one
            vector_map_pkg::src_timer1_capture: vector_number = 5'h0b;
            vector_map_pkg::src_timer1_compare_a: vector_number = 5'h0c;
            vector_map_pkg::src_timer1_compare_b: vector_number = 5'h0d;
            vector_map_pkg::src_timer1_overflow: vector_number = 5'h0e;

            // Timer zero
            vector_map_pkg::src_timer0_compare_a: vector_number = 5'h0f;
            vector_map_pkg::src_timer0_compare_b: vector_number = 5'h10;
            vector_map_pkg::src_timer0_overflow: vector_number = 5'h11;

            // Serial peripheral
            vector_map_pkg::src_transfer_complete: vector_number = 5'h12;

            // Serial port
            vector_map_pkg::src_rx_complete: vector_number = 5'h13;
            vector_map_pkg::src_tx_buffer_empty: vector_number = 5'h14;
            vector_map_pkg::src_tx_complete: vector_number = 5'h15;

            // Converter, data memory, comparator
            vector_map_pkg::src_conversion_complete: vector_number = 5'h16;
            vector_map_pkg::src_nv_data_ready: vector_number = 5'h17;
            vector_map_pkg::src_analog_compare: vector_number = 5'h18;

            // Two-wire unit and program store, the last slot
            vector_map_pkg::src_two_wire_serial_unit: vector_number = 5'h19;
            vector_map_pkg::src_program_store_ready: vector_number = 5'h1a;
            default:
            begin
                vector_number = 5'h00;
            end
        endcase
    endfunction

    // Vector number n sits at (n-1)*2 from the base
    function automatic vector_map_pkg::pc_t vector_addr(
        input vector_map_pkg::pc_t base,
        input logic [`VEC_WIDTH-1:0] vec
    );
        logic [`VEC_WIDTH-1:0] vec_minus_one;
        vec_minus_one = `VEC_WIDTH'(vec - `VEC_WIDTH'h01);
        vector_addr = `PC_WIDTH'(base + `PC_WIDTH'(vec_minus_one) * `VEC_SPACING);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fuse is a static strap but arrives from outside; filter it anyway
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            fuse_s1 <= 1'b1;
            fuse_s2 <= 1'b1;
            fuse_s3 <= 1'b1;
        end
        else
        begin
            fuse_s1 <= boot_reset_fuse;
            fuse_s2 <= fuse_s1;
            fuse_s3 <= fuse_s2;
        end
    end

    // Filter flops reset to the unprogrammed level; that value must not be
    // taken for the fuse, so wait until real samples have filled the chain
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            settle_count <= 2'h0;
        end
        else if (settle_count != `FUSE_SETTLE)
        begin
            settle_count <= settle_count + 2'h1;
        end
    end

    assign fuse_settled = (settle_count == `FUSE_SETTLE) && (fuse_s2 == fuse_s3);

    // Out-of-range source numbers are dropped rather than aliased
    assign source_ok = irq_source < `SRC_WIDTH'(`SRC_COUNT);
    assign reset_fetch = (state == vector_map_pkg::st_reset_pending) && fuse_settled;
    // Vector slots are only fetched on an accepted interrupt
    assign irq_fetch = (state == vector_map_pkg::st_running) && irq_accept && source_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Reset vector is issued once, after the fuse filter has settled
    always_comb
    begin
        next_state = state;
        case (state)
            vector_map_pkg::st_reset_pending:
            begin
                if (fuse_settled)
                begin
                    next_state = vector_map_pkg::st_running;
                end
            end
            vector_map_pkg::st_running:
            begin
                next_state = vector_map_pkg::st_running;
            end
            default:
            begin
                next_state = vector_map_pkg::st_reset_pending;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state <= vector_map_pkg::st_reset_pending;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset placement follows only the fuse, vector placement only the select bit;
    // a fuse change after reset does not move the reset fetch
    always_comb
    begin
        vector_base = `RESET_ADDR;
        next_addr = fetch_addr;
        next_valid = reset_fetch || irq_fetch;
        next_is_reset = reset_fetch;
        if (reset_fetch)
        begin
            if (fuse_s3 == `FUSE_PROGRAMMED)
            begin
                next_addr = boot_start;
            end
            else
            begin
                next_addr = `RESET_ADDR;
            end
        end
        else if (irq_fetch)
        begin
            if (vector_base_select)
            begin
                vector_base = boot_start;
            end
            next_addr = vector_addr(vector_base, vector_number(irq_source));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs come straight from flops; the address holds between pulses
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            fetch_valid <= 1'b0;
        end
        else
        begin
            fetch_valid <= next_valid;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            fetch_is_reset <= 1'b0;
        end
        else
        begin
            fetch_is_reset <= next_is_reset;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            fetch_addr <= `RESET_ADDR;
        end
        else
        begin
            fetch_addr <= next_addr;
        end
    end

endmodule // reset_interrupt_vector_mapper

// File: bench/vec_map_props.sv
// Purpose: Vector mapper port checks
// Assumes: Inputs move at falling edges
// Notes: Raw reset disables all checks
`timescale 1ns/10ps
module vec_map_props(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Controls
    input wire logic boot_reset_fuse,
    input wire logic vector_base_select,
    input wire logic [13:0] boot_start,
    input wire logic irq_accept,
    input wire logic [4:0] irq_source,
    // Fetch
    input wire logic fetch_valid,
    input wire logic fetch_is_reset,
    input wire logic [13:0] fetch_addr
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic [13:0] off = {8'h00, irq_source, 1'b0} + 14'h0002;
    wire logic [13:0] boff = off + boot_start;
    wire logic ok = irq_accept && irq_source < 5'h19;
    app_vec_a: assert property (ok && !vector_base_select
        |=> fetch_valid && fetch_addr == $past(off)) else $error("app vector");
    boot_vec_a: assert property (ok && vector_base_select
        |=> fetch_valid && fetch_addr == $past(boff)) else $error("boot vector");
    rst_addr_a: assert property (fetch_is_reset
        |-> fetch_addr == (boot_reset_fuse ? 14'h0000 : boot_start)) else $error("reset addr");
    refused_a: assert property (irq_accept && !ok
        |=> !fetch_valid) else $error("refused source");
    taken_only_a: assert property (fetch_valid && !fetch_is_reset
        |-> $past(ok)) else $error("fetch untaken");
    rst_once_a: assert property (fetch_is_reset
        |-> fetch_valid ##1 !fetch_is_reset) else $error("reset pulse");
    addr_hold_a: assert property (!fetch_valid
        |-> $stable(fetch_addr)) else $error("addr moved");
    rst_fetch_a: assert property ($rose(rst_n)
        |-> ##[1:8] fetch_is_reset) else $error("no reset fetch");
endmodule // vec_map_props
bind reset_interrupt_vector_mapper vec_map_props u_props(.*);

// File: bench/core_fetch_model.sv
// Purpose: Core fetch side model
// Assumes: Fetch pulses last one cycle
// Notes: Counts fetches only
`timescale 1ns/10ps
module core_fetch_model(
    // Fetch input
    input wire logic clock,
    input wire logic fetch_valid,
    // Record
    output int n_fetch
);
    int count = 0;
    assign n_fetch = count;
    // Core takes one fetch per cycle that fetch_valid is high
    always @(posedge clock)
        if (fetch_valid === 1'b1)
            count <= count + 1;
endmodule // core_fetch_model

// File: bench/reset_interrupt_vector_mapper_tb_top.sv
// Purpose: Vector mapper bench
// Assumes: Inputs change at falling edges
// Notes: Boot start fixed at default
`timescale 1ns/10ps
`include "vector_map_defines.svh"
module reset_interrupt_vector_mapper_tb_top;
    logic clock = 1'b0, rst_n = 1'b0, fuse = 1'b1, sel = 1'b0, acc = 1'b0, fv, fr;
    logic [4:0] src = 5'h00;
    logic [13:0] fa, bs = `BOOT_START_DEFAULT;
    int n_fetch, n_errors = 0, checks = 0, cyc = 0;
    reset_interrupt_vector_mapper dut(.clock(clock), .rst_n(rst_n), .boot_reset_fuse(fuse),
        .vector_base_select(sel), .boot_start(bs), .irq_accept(acc), .irq_source(src),
        .fetch_valid(fv), .fetch_is_reset(fr), .fetch_addr(fa));
    core_fetch_model core(.clock(clock), .fetch_valid(fv), .n_fetch(n_fetch));
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string what, logic [14:0] exp, logic [14:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic reset_test(logic f);
        int i;
        fuse = f;
        rst_n = 1'b0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        for (i = 0; i < 20 && fr !== 1'b1; i++) @(negedge clock);
        chk("reset", {1'b1, f ? 14'h0000 : bs}, {fv, fa});
        @(negedge clock);
        $display("reset test ended");
    endtask
    task automatic table_test(logic s);
        int i;
        // Base chosen before any accept is raised
        sel = s;
        acc = 1'b1;
        for (i = 0; i < 25; i++)
        begin
            src = i[4:0];
            @(negedge clock);
            chk("vector", {1'b1, (s ? bs : 14'h0000) + 14'(2 * i + 2)}, {fv, fa});
            chk("kind", 15'h0000, {14'h0000, fr});
        end
        acc = 1'b0;
        @(negedge clock);
        $display("table test ended");
    endtask
    task automatic refuse_test();
        int i;
        acc = 1'b1;
        for (i = 25; i < 32; i++)
        begin
            src = i[4:0];
            @(negedge clock);
            chk("refused", {1'b0, 14'h0032}, {fv, fa});
        end
        acc = 1'b0;
        @(negedge clock);
        chk("count", 15'h001a, n_fetch[14:0]);
        $display("refuse test ended");
    endtask
    initial forever #2.5 clock = ~clock;
    always @(posedge clock)
        if (++cyc == 1000)
        begin
            n_errors++;
            stop_test();
        end
    initial
    begin
        reset_test(1'b1);
        table_test(1'b0);
        refuse_test();
        table_test(1'b1);
        reset_test(1'b0);
        table_test(1'b0);
        stop_test();
    end
endmodule // reset_interrupt_vector_mapper_tb_top
